// ==== src/ubc_core.sv ====
// Baud generator, enables, pin mapping and register slave of the serial port.
`timescale 1ns/1ps
`default_nettype none
module ubc_core
   import ubc_pkg::*;
(
   input  wire logic        pclk,             // Peripheral clock, 10 MHz.
   input  wire logic        presetn,          // Asynchronous reset, active low.
   input  wire logic        psel,             // APB select.
   input  wire logic        penable,          // APB access phase.
   input  wire logic        pwrite,           // APB direction, high for write.
   input  wire logic [15:0] paddr,            // APB byte address.
   input  wire logic [31:0] pwdata,           // APB write data.
   output logic      [31:0] prdata,           // APB read data.
   output logic             pready,           // APB ready.
   output logic             pslverr,          // APB error for unmapped address.
   input  wire logic        ext_timer_out,    // External timer output used as base clock.
   input  wire logic        serial_tx_data,   // Serial data from the transmit shifter.
   output logic             serial_rx_data,   // Receive input seen by the receive shifter.
   input  wire logic [7:0]  port1_in,         // Port 1 pin levels.
   output logic [7:0]       port1_out,        // Port 1 pin output values.
   output logic [7:0]       port1_oe,         // Port 1 pin output enables, high drives.
   output logic             bit_tick,         // One-cycle pulse per bit period.
   output logic             tx_circuit_rst,   // Transmit circuit held in reset.
   output logic             rx_circuit_rst,   // Receive circuit held in reset.
   output logic             port_clear        // Status and receive buffer cleared.
);

   // Software-visible registers.
   logic [7:0] port1_direction_r;     // Port 1 direction, one bit per pin.
   logic [7:0] port1_latch_r;         // Port 1 output latch.
   logic [7:0] serial_mode_control_r; // Power, enables and format bits.
   logic [7:0] baud_divisor_r;        // Divisor field k.
   logic [3:0] base_clock_select_r;   // Base clock select code.
   logic       bit_clk_r;             // Bit clock flip-flop, toggled on each divider wrap.

   // Decoded mode bits.
   logic port_power;
   logic transmit_enable;
   logic receive_enable;
   assign port_power      = serial_mode_control_r[UBC_BIT_POWER];
   assign transmit_enable = serial_mode_control_r[UBC_BIT_TXEN];
   assign receive_enable  = serial_mode_control_r[UBC_BIT_RXEN];

   // Synchronisers for pins and the timer clock.
   logic       tmr_meta_r;
   logic       tmr_sync_r;
   logic       tmr_prev_r;
   logic       sin_meta_r;
   logic       sin_sync_r;

   // APB decode helpers.
   logic       wr_fire;
   logic       rd_fire;
   logic       mapped;
   logic [7:0] wbyte;
   assign wr_fire = psel & penable & pwrite & pready;
   assign rd_fire = psel & ~pready & ~pwrite;
   assign wbyte   = pwdata[7:0];

   // Checks whether an address hits a register.
   function automatic logic is_mapped(input logic [15:0] a);
      is_mapped = (a == UBC_OFS_PORT1_DIR) || (a == UBC_OFS_MODE_CTRL) || (a == UBC_OFS_CLK_SEL) ||
                  (a == UBC_OFS_DIVISOR) || (a == UBC_OFS_PORT1_LATCH) || (a == UBC_OFS_STATUS);
   endfunction
   assign mapped = is_mapped(paddr);

   // Bus handshake: one wait state, ready raised in the access phase.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end else if (psel && penable && !pready) begin
         pready  <= 1'b1;
         pslverr <= ~mapped;
      end else begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end
   end

   // Read data is registered while the access waits for ready.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
      end else if (rd_fire) begin
         unique case (paddr)
            UBC_OFS_PORT1_DIR:   prdata <= {24'h000000, port1_direction_r};
            UBC_OFS_PORT1_LATCH: prdata <= {24'h000000, port1_latch_r};
            UBC_OFS_MODE_CTRL:   prdata <= {24'h000000, serial_mode_control_r};
            UBC_OFS_CLK_SEL:     prdata <= {28'h0000000, base_clock_select_r};
            UBC_OFS_DIVISOR:     prdata <= {24'h000000, baud_divisor_r};
            UBC_OFS_STATUS:      prdata <= {29'h00000000, bit_clk_r, tx_circuit_rst, rx_circuit_rst};
            default:             prdata <= 32'h0000_0000;
         endcase
      end
   end

   // Mode control register; reset value 01h.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         serial_mode_control_r <= UBC_RST_MODE_CTRL;
      end else if (wr_fire && paddr == UBC_OFS_MODE_CTRL) begin
         serial_mode_control_r <= wbyte;
      end
   end

   // Divisor register; a same-value rewrite leaves the counter untouched.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         baud_divisor_r <= UBC_RST_DIVISOR;
      end else if (wr_fire && paddr == UBC_OFS_DIVISOR) begin
         baud_divisor_r <= wbyte;
      end
   end

   // Base clock select register, low four bits kept.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         base_clock_select_r <= UBC_RST_CLK_SEL;
      end else if (wr_fire && paddr == UBC_OFS_CLK_SEL) begin
         base_clock_select_r <= wbyte[3:0];
      end
   end

   // Port direction and output latch registers.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         port1_direction_r <= UBC_RST_PORT1_DIR;
         port1_latch_r     <= UBC_RST_PORT1_LATCH;
      end else if (wr_fire) begin
         if (paddr == UBC_OFS_PORT1_DIR) begin
            port1_direction_r <= wbyte;
         end
         if (paddr == UBC_OFS_PORT1_LATCH) begin
            port1_latch_r <= wbyte;
         end
      end
   end

   // Two-stage synchronisers for every asynchronous input.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tmr_meta_r <= 1'b0;
         tmr_sync_r <= 1'b0;
         tmr_prev_r <= 1'b0;
         sin_meta_r <= 1'b1;
         sin_sync_r <= 1'b1;
      end else begin
         tmr_meta_r <= ext_timer_out;
         tmr_sync_r <= tmr_meta_r;
         tmr_prev_r <= tmr_sync_r;
         sin_meta_r <= port1_in[UBC_PIN_RX];
         sin_sync_r <= sin_meta_r;
      end
   end

   // Prescaler: free counter whose bit n-1 carry gives fprs/2^n enables.
   logic [9:0]  pre_cnt_r;
   logic [10:0] pre_carry;
   logic        base_en;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pre_cnt_r <= 10'h000;
      end else if (!port_power) begin
         pre_cnt_r <= 10'h000;
      end else begin
         pre_cnt_r <= pre_cnt_r + 10'h001;
      end
   end

   // Carry chain: stage n fires when the low n bits are all ones.
   assign pre_carry[0] = 1'b1;
   generate
      for (genvar g = 1; g <= 10; g++) begin : g_carry
         assign pre_carry[g] = pre_carry[g-1] & pre_cnt_r[g-1];
      end
   endgenerate

   // Base clock enable selection.
   always_comb begin
      if (base_clock_select_r <= UBC_SEL_MAX_DIV) begin
         base_en = pre_carry[base_clock_select_r];
      end else if (base_clock_select_r == UBC_SEL_EXT_TMR) begin
         base_en = tmr_sync_r & ~tmr_prev_r;
      end else begin
         base_en = 1'b0;
      end
   end

   // Divider counter counts base clocks 0..k-1 and wraps.
   logic [7:0] div_cnt_r;
   logic       div_wrap;
   logic       div_ok;
   assign div_ok   = baud_divisor_r >= UBC_DIV_MIN;
   assign div_wrap = base_en && div_ok && (div_cnt_r == baud_divisor_r - 8'h01);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         div_cnt_r <= 8'h00;
      end else if (!port_power) begin
         div_cnt_r <= 8'h00;
      end else if (div_wrap) begin
         div_cnt_r <= 8'h00;
      end else if (base_en && div_ok) begin
         div_cnt_r <= div_cnt_r + 8'h01;
      end
   end

   // Bit clock flip-flop toggles on each wrap; one bit per two wraps.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         bit_clk_r <= 1'b0;
         bit_tick  <= 1'b0;
      end else if (!port_power) begin
         bit_clk_r <= 1'b0;
         bit_tick  <= 1'b0;
      end else begin
         if (div_wrap) begin
            bit_clk_r <= ~bit_clk_r;
         end
         bit_tick <= div_wrap & bit_clk_r;
      end
   end

   // Circuit resets follow power and enables.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_circuit_rst <= 1'b1;
         rx_circuit_rst <= 1'b1;
         port_clear     <= 1'b1;
      end else begin
         port_clear     <= ~port_power;
         tx_circuit_rst <= ~port_power | ~transmit_enable;
         rx_circuit_rst <= ~port_power | ~receive_enable;
      end
   end

   // Pin mapping: serial function only while powered and enabled.
   logic tx_serial;
   logic rx_serial;
   assign tx_serial = port_power & transmit_enable;
   assign rx_serial = port_power & receive_enable;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         port1_out      <= UBC_RST_PORT1_LATCH;
         port1_oe       <= 8'h00;
         serial_rx_data <= 1'b1;
      end else begin
         port1_oe  <= ~port1_direction_r;
         port1_out <= port1_latch_r;
         if (tx_serial) begin
            port1_out[UBC_PIN_TX] <= serial_tx_data & port1_latch_r[UBC_PIN_TX];
         end else if (!port_power && transmit_enable) begin
            port1_out[UBC_PIN_TX] <= 1'b1;
         end
         serial_rx_data <= rx_serial ? sin_sync_r : 1'b1;
      end
   end

   // Bit tick stays low the cycle after power is seen off.
   property p_no_tick_off;
      @(posedge pclk) disable iff (!presetn)
      !port_power |=> !bit_tick;
   endproperty
   chk_power_off_quiet: assert property (p_no_tick_off) else $error("bit tick while powered off");

   // Counter never passes k-1.
   chk_div_range: assert property (@(posedge pclk) disable iff (!presetn)
      (port_power && div_ok && $stable(baud_divisor_r)) |-> div_cnt_r < baud_divisor_r)
      else $error("divider counter out of range");

   // A wrap flips the bit clock one cycle later.
   chk_wrap_toggle: assert property (@(posedge pclk) disable iff (!presetn)
      (port_power && div_wrap) ##1 port_power |-> bit_clk_r != $past(bit_clk_r))
      else $error("bit clock did not toggle");

   // Tick only on the second of two wraps.
   chk_tick_half: assert property (@(posedge pclk) disable iff (!presetn)
      bit_tick |-> !bit_clk_r && $past(bit_clk_r))
      else $error("bit tick not on falling bit clock");

   // Transmit reset follows the enable within one cycle.
   chk_tx_reset: assert property (@(posedge pclk) disable iff (!presetn)
      !transmit_enable |=> tx_circuit_rst)
      else $error("transmit circuit not reset");

   // Receive reset follows the enable within one cycle.
   chk_rx_reset: assert property (@(posedge pclk) disable iff (!presetn)
      !receive_enable |=> rx_circuit_rst)
      else $error("receive circuit not reset");

   // Power off clears status and forces receive input high.
   sequence s_power_off;
      !port_power ##1 !port_power;
   endsequence
   chk_power_clear: assert property (@(posedge pclk) disable iff (!presetn)
      s_power_off |-> port_clear && serial_rx_data)
      else $error("power off did not clear port");

   // Direction bit zero drives the pin.
   chk_dir_drive: assert property (@(posedge pclk) disable iff (!presetn)
      ##1 port1_oe == ~$past(port1_direction_r))
      else $error("output enable mismatch");

   // Transmit pin is a plain port pin when power and transmit enable are both off.
   chk_tx_plain: assert property (@(posedge pclk) disable iff (!presetn)
      (!port_power && !transmit_enable) |=> port1_out[UBC_PIN_TX] == $past(port1_latch_r[UBC_PIN_TX]))
      else $error("tx pin not in port mode");

   // Receive data follows the synchronised pin while reception is on.
   chk_rx_follow: assert property (@(posedge pclk) disable iff (!presetn)
      rx_serial |=> serial_rx_data == $past(sin_sync_r))
      else $error("receive data not taken from pin");

   // A power cut with transmit still enabled parks the tx pin high.
   chk_tx_forced_high: assert property (@(posedge pclk) disable iff (!presetn)
      (!port_power && transmit_enable) |=> port1_out[UBC_PIN_TX])
      else $error("tx pin not forced high");
endmodule
`default_nettype wire

// ==== src/ubc_pkg.sv ====
// Package with register map, field positions, reset values and counts for the serial port control block.
package ubc_pkg;
   // Register byte addresses on the peripheral bus.
   localparam logic [15:0] UBC_OFS_PORT1_DIR   = 16'hff21;
   localparam logic [15:0] UBC_OFS_MODE_CTRL   = 16'hff50;
   localparam logic [15:0] UBC_OFS_CLK_SEL     = 16'hff56;
   localparam logic [15:0] UBC_OFS_DIVISOR     = 16'hff57;
   localparam logic [15:0] UBC_OFS_PORT1_LATCH = 16'hff01;
   localparam logic [15:0] UBC_OFS_STATUS      = 16'hff60;
   // Values after reset.
   localparam logic [7:0] UBC_RST_PORT1_DIR   = 8'hff;
   localparam logic [7:0] UBC_RST_MODE_CTRL   = 8'h01;
   localparam logic [7:0] UBC_RST_DIVISOR     = 8'hff;
   localparam logic [3:0] UBC_RST_CLK_SEL     = 4'h0;
   localparam logic [7:0] UBC_RST_PORT1_LATCH = 8'h00;
   // Mode control field positions.
   localparam int UBC_BIT_POWER  = 7;
   localparam int UBC_BIT_TXEN   = 6;
   localparam int UBC_BIT_RXEN   = 5;
   // Port 1 pin positions for the serial pins.
   localparam int UBC_PIN_TX     = 3;
   localparam int UBC_PIN_RX     = 4;
   // Smallest legal divisor and the base clock select codes.
   localparam logic [7:0] UBC_DIV_MIN      = 8'h04;
   localparam logic [3:0] UBC_SEL_MAX_DIV  = 4'ha;
   localparam logic [3:0] UBC_SEL_EXT_TMR  = 4'hb;
endpackage

// ==== tb/uart_baud_enable_control_tb_top.sv ====
// Self-checking bench for the serial port control block.
`timescale 1ns/1ps
`default_nettype none
module uart_baud_enable_control_tb_top;
   import ubc_pkg::*;
   logic        pclk = 1'b0;           // Peripheral clock.
   logic        presetn = 1'b0;        // Reset, active low.
   logic        psel = 1'b0;           // Bus select.
   logic        penable = 1'b0;        // Bus access phase.
   logic        pwrite = 1'b0;         // Bus direction.
   logic [15:0] paddr = 16'h0000;      // Bus address.
   logic [31:0] pwdata = 32'h00000000; // Bus write data.
   logic        ext_timer_out = 1'b0;  // External base clock.
   logic        serial_tx_data = 1'b1; // Transmit shifter data.
   logic        send_en = 1'b0;        // Remote side drives its line.
   logic        send_bit = 1'b1;       // Remote side line level.
   logic [31:0] prdata;                // Bus read data.
   logic        pready;                // Bus ready.
   logic        pslverr;               // Bus error.
   logic        serial_rx_data;        // Receive data to the shifter.
   logic [7:0]  port1_in;              // Port pin levels.
   logic [7:0]  port1_out;             // Port output values.
   logic [7:0]  port1_oe;              // Port output enables.
   logic        bit_tick;              // Bit period pulse.
   logic        tx_circuit_rst;        // Transmit circuit reset.
   logic        rx_circuit_rst;        // Receive circuit reset.
   logic        port_clear;            // Status clear.
   logic        rx_line;               // Remote side line.
   int          n_errors = 0;          // Mismatches seen.
   int          checks_done = 0;       // Comparisons made.
   int          cyc = 0;               // Cycles run.
   int          tmr_div = 0;           // Timer half-period counter.
   // Undriven pins sit at their pull-up; pin 4 carries the remote line when released.
   assign port1_in = (port1_oe & port1_out) | (~port1_oe & {3'h7, rx_line, 4'hf});
   ubc_core u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .ext_timer_out(ext_timer_out), .serial_tx_data(serial_tx_data), .serial_rx_data(serial_rx_data),
      .port1_in(port1_in), .port1_out(port1_out), .port1_oe(port1_oe), .bit_tick(bit_tick),
      .tx_circuit_rst(tx_circuit_rst), .rx_circuit_rst(rx_circuit_rst), .port_clear(port_clear));
   ubc_remote_dev u_remote (.send_en(send_en), .send_bit(send_bit), .rx_line(rx_line));
   // Clock at 10 MHz and a slow timer output with a rising edge every six cycles.
   always #50 pclk = ~pclk;
   always @(posedge pclk) begin
      tmr_div <= (tmr_div == 2) ? 0 : tmr_div + 1;
      if (tmr_div == 2) begin
         ext_timer_out <= ~ext_timer_out;
      end
   end
   // Cuts a hung run short.
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 20000) begin
         n_errors++;
         wrap_up();
      end
   end
   // Prints the counts and the verdict, then ends the run.
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   // Compares a seen value with the expected one.
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         n_errors++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   // One bus transfer: setup, then access held until ready is sampled high.
   task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // Writes a register and lets its effects land.
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      logic [31:0] r;
      logic        e;
      apb(1'b1, a, {24'h000000, d}, r, e);
      repeat (5) @(posedge pclk);
   endtask
   // Reads a register and compares data and error.
   task automatic rd(input logic [15:0] a, input logic [31:0] exp, input logic exp_e);
      logic [31:0] r;
      logic        e;
      apb(1'b0, a, 32'h00000000, r, e);
      check(r, exp);
      check(e, exp_e);
   endtask
   // Measures cycles between two bit ticks.
   task automatic period(input int exp);
      int n;
      for (int i = 0; i < 2; i++) begin
         n = 0;
         do begin
            @(posedge pclk);
            n++;
         end while (bit_tick !== 1'b1 && n < 1000);
      end
      check(n, exp);
   endtask
   // Expects no tick over a stretch of cycles.
   task automatic no_tick();
      int n;
      n = 0;
      repeat (100) begin
         @(posedge pclk);
         n += (bit_tick !== 1'b0);
      end
      check(n, 0);
   endtask
   // Reset values of the direction, mode, divisor and select registers and of the resets, enables and receive data, and a refused address.
   task automatic t_reset();
      check(port1_oe, 8'h00);
      check({tx_circuit_rst, rx_circuit_rst, serial_rx_data}, 3'h7);
      no_tick();
      rd(UBC_OFS_PORT1_DIR, 32'h000000ff, 1'b0);
      rd(UBC_OFS_MODE_CTRL, 32'h00000001, 1'b0);
      rd(UBC_OFS_DIVISOR, 32'h000000ff, 1'b0);
      rd(UBC_OFS_CLK_SEL, 32'h00000000, 1'b0);
      rd(16'hff00, 32'h00000000, 1'b1);
      $display("test reset done");
   endtask
   // Direction and latch reach the pins while the port is stopped.
   task automatic t_pins();
      wr(UBC_OFS_PORT1_DIR, 8'hf0);
      wr(UBC_OFS_PORT1_LATCH, 8'ha5);
      check(port1_oe, 8'h0f);
      check(port1_out, 8'ha5);
      wr(UBC_OFS_MODE_CTRL, 8'h1e);
      rd(UBC_OFS_MODE_CTRL, 32'h0000001e, 1'b0);
      $display("test pins done");
   endtask
   // Bit period for several selects and divisors, set up in the documented order.
   task automatic t_baud();
      logic [3:0] sel [4] = '{4'h0, 4'h1, 4'h0, 4'hb};
      logic [7:0] k [4] = '{8'h04, 8'h05, 8'hff, 8'h04};
      int         exp [4] = '{8, 20, 510, 48};
      for (int i = 0; i < 4; i++) begin
         wr(UBC_OFS_CLK_SEL, {4'h0, sel[i]});
         wr(UBC_OFS_DIVISOR, k[i]);
         wr(UBC_OFS_MODE_CTRL, 8'h81);
         wr(UBC_OFS_MODE_CTRL, 8'he1);
         period(exp[i]);
         wr(UBC_OFS_DIVISOR, k[i]);
         period(exp[i]);
         wr(UBC_OFS_MODE_CTRL, 8'h81);
         wr(UBC_OFS_MODE_CTRL, 8'h01);
         no_tick();
      end
      wr(UBC_OFS_DIVISOR, 8'h03);
      wr(UBC_OFS_MODE_CTRL, 8'h81);
      no_tick();
      wr(UBC_OFS_MODE_CTRL, 8'h01);
      wr(UBC_OFS_DIVISOR, 8'h04);
      $display("test baud done");
   endtask
   // Each enable releases its own circuit and takes over its own pin.
   task automatic t_enable();
      wr(UBC_OFS_PORT1_DIR, 8'hf7);
      wr(UBC_OFS_PORT1_LATCH, 8'h08);
      serial_tx_data <= 1'b0;
      send_en <= 1'b1;
      send_bit <= 1'b0;
      wr(UBC_OFS_MODE_CTRL, 8'h81);
      check({tx_circuit_rst, rx_circuit_rst, port_clear}, 3'h6);
      check({port1_out[3], serial_rx_data}, 2'h3);
      wr(UBC_OFS_MODE_CTRL, 8'hc1);
      check({tx_circuit_rst, rx_circuit_rst}, 2'h1);
      check({port1_out[3], serial_rx_data}, 2'h1);
      wr(UBC_OFS_MODE_CTRL, 8'ha1);
      check({tx_circuit_rst, rx_circuit_rst}, 2'h2);
      check({port1_out[3], serial_rx_data}, 2'h2);
      $display("test enable done");
   endtask
   // Power cut in mid transfer forces both serial lines high and clears state.
   task automatic t_power_drop();
      wr(UBC_OFS_MODE_CTRL, 8'he1);
      check({port1_out[3], serial_rx_data}, 2'h0);
      wr(UBC_OFS_MODE_CTRL, 8'h61);
      check({port1_out[3], serial_rx_data}, 2'h3);
      check({port_clear, tx_circuit_rst, rx_circuit_rst}, 3'h7);
      no_tick();
      serial_tx_data <= 1'b1;
      send_en <= 1'b0;
      wr(UBC_OFS_MODE_CTRL, 8'h01);
      $display("test power drop done");
   endtask
   // Main sequence.
   initial begin
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      t_reset();
      t_pins();
      t_baud();
      t_enable();
      t_power_drop();
      wrap_up();
   end
endmodule
`default_nettype wire

// ==== tb/ubc_remote_dev.sv ====
// Model of the remote serial device that drives the port's receive pin.
`timescale 1ns/1ps
`default_nettype none
module ubc_remote_dev (
   input  wire logic send_en,  // High while the remote side drives its line.
   input  wire logic send_bit, // Level driven while sending.
   output logic      rx_line   // Level seen on the receive pin.
);
   // A released line returns to its pull-up level, which is also the idle level between frames.
   assign rx_line = send_en ? send_bit : 1'b1;
endmodule
`default_nettype wire
